// *** core/dma_ring_csr.sv ***
// Ring DMA engine controls, status, descriptor walkers and bus master arbiter
// Functional notes
// [RULE_01] Byte order bit 7: 0 little, 1 big endian, data buffers only.
// [RULE_02] Bits 6:2 give the word gap inserted between ring descriptors.
// [RULE_03] Bit 1: 0 favours receive on the bus, 1 favours transmit.
// [RULE_04] Writing bit 0 resets internal logic; bit clears itself when done.
// [RULE_05] Software stops both processes before writing the config word.
// [RULE_06] Transmit poll in suspend fetches descriptor; owned descriptor resumes sending.
// [RULE_07] Receive poll in suspend fetches descriptor; owned descriptor starts FIFO draining.
// [RULE_08] Software polls transmit only while transmit is suspended.
// [RULE_09] Software polls receive only while receive is suspended.
// [RULE_10] Receive ring base holds bits 31:2; bits 1:0 read zero.
// [RULE_11] Transmit ring base holds bits 31:2; bits 1:0 read zero.
// [RULE_12] Software writes receive ring base only while receive is stopped.
// [RULE_13] Software writes transmit ring base only while transmit is stopped.
// [RULE_14] Status 25:23 give bus fault kind, valid with fatal bit 13.
// [RULE_15] Status 22:20 show transmit state codes; 100 and 101 unused.
// [RULE_16] Status 19:17 show receive state codes, all eight defined.
// [RULE_17] Summary bit 16 latches when bit 0, 2 or 6 is set.
// [RULE_18] Reserved config and status bits read zero and ignore writes.
module dma_ring_csr import ring_dma_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire reg_req_t i_reg,
	output logic [31:0] o_reg_rdata,
	input wire logic i_tx_run,
	input wire logic i_rx_run,
	output dma_req_t o_dma,
	output logic o_dma_req,
	input wire logic i_dma_ack,
	input wire logic i_dma_err,
	input wire logic [2:0] i_dma_err_kind,
	input wire logic [31:0] i_dma_rdata,
	output logic [31:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire rx_word_t i_rx_word,
	input wire logic i_rx_valid,
	output logic o_rx_ready
);
	////////////////////////////////////////////////////////////////////////////
	// Soft reset and register decode
	logic soft_busy;
	logic rst_ok;
	logic wr_cfg, wr_txp, wr_rxp, wr_rxb, wr_txb, wr_st;

	assign wr_cfg = i_reg.wr && i_reg.addr == OFF_BUS_ACCESS_CONFIG;
	assign wr_txp = i_reg.wr && i_reg.addr == OFF_TX_POLL_PORT;
	assign wr_rxp = i_reg.wr && i_reg.addr == OFF_RX_POLL_PORT;
	assign wr_rxb = i_reg.wr && i_reg.addr == OFF_RX_RING_BASE;
	assign wr_txb = i_reg.wr && i_reg.addr == OFF_TX_RING_BASE;
	assign wr_st = i_reg.wr && i_reg.addr == OFF_MAIN_STATUS_WORD;

	soft_reset_seq u_seq (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_start(wr_cfg && i_reg.wdata[CFG_SOFT_RESET_BIT]), // [RULE_04]
		.o_busy(soft_busy)
	);
	assign rst_ok = i_rstn && !soft_busy; // [RULE_04]

	////////////////////////////////////////////////////////////////////////////
	// Configuration and ring bases
	logic [7:1] cfg_r;
	logic [31:2] rx_base_r, tx_base_r;
	logic big, tx_first;
	logic [4:0] gap;
	logic [31:0] rx_base, tx_base;

	always_ff @(posedge i_sys_clk) begin
		if (!rst_ok) begin
			cfg_r <= CFG_RESET;
			rx_base_r <= RING_BASE_RESET[31:2];
			tx_base_r <= RING_BASE_RESET[31:2];
		end else begin
			if (wr_cfg) cfg_r <= i_reg.wdata[7:1]; // [RULE_18]
			if (wr_rxb) rx_base_r <= i_reg.wdata[31:2]; // [RULE_10]
			if (wr_txb) tx_base_r <= i_reg.wdata[31:2]; // [RULE_11]
		end
	end

	assign big = cfg_r[CFG_BYTE_ORDER_BIT];
	assign tx_first = cfg_r[CFG_PRIORITY_BIT];
	assign gap = cfg_r[CFG_GAP_MSB:CFG_GAP_LSB];
	assign rx_base = {rx_base_r, 2'b00}; // [RULE_10]
	assign tx_base = {tx_base_r, 2'b00}; // [RULE_11]

	////////////////////////////////////////////////////////////////////////////
	// Bus master arbiter
	arb_t grant_r;
	logic tx_req, rx_req, tx_ack, rx_ack, fatal_r;
	dma_req_t tx_dma, rx_dma;

	always_ff @(posedge i_sys_clk) begin
		if (!rst_ok) begin
			grant_r <= ARB_IDLE;
		end else if (grant_r != ARB_IDLE) begin
			if (i_dma_ack || i_dma_err) grant_r <= ARB_IDLE;
		end else if (tx_req && (tx_first || !rx_req)) begin
			grant_r <= ARB_TX; // [RULE_03]
		end else if (rx_req) begin
			grant_r <= ARB_RX; // [RULE_03]
		end
	end

	assign tx_ack = i_dma_ack && grant_r == ARB_TX;
	assign rx_ack = i_dma_ack && grant_r == ARB_RX;
	assign o_dma_req = grant_r != ARB_IDLE;
	assign o_dma = (grant_r == ARB_RX) ? rx_dma : tx_dma;

	////////////////////////////////////////////////////////////////////////////
	// Transmit walker
	tx_state_t tx_st_r;
	logic [31:0] tx_cur_r, tx_buf_r, tx_data_r;
	logic [7:0] tx_len_r, tx_cnt_r;
	logic tx_ph_r, tx_eor_r, tx_done_ev, tx_miss_ev;

	assign tx_req = !fatal_r && (tx_st_r == TX_DREAD || tx_st_r == TX_FILL || tx_st_r == TX_DWRITE);
	assign tx_dma.write = tx_st_r == TX_DWRITE;
	assign tx_dma.addr = (tx_st_r == TX_FILL) ? tx_buf_r + {22'h0, tx_cnt_r, 2'b00}
		: tx_cur_r + (tx_ph_r ? DESC_WORD1_OFFSET : 32'h0);
	assign tx_dma.wdata = {1'b0, tx_eor_r, 22'h0, tx_len_r};
	assign tx_done_ev = tx_ack && tx_st_r == TX_DWRITE;
	assign tx_miss_ev = tx_ack && tx_st_r == TX_DREAD && !tx_ph_r && !i_dma_rdata[DESC_OWN_BIT];
	assign o_tx_valid = tx_st_r == TX_XMIT;
	assign o_tx_data = tx_data_r;

	always_ff @(posedge i_sys_clk) begin
		if (!rst_ok || i_dma_err) begin
			tx_st_r <= TX_STOP;
			tx_ph_r <= 1'b0;
		end else begin
			unique case (tx_st_r)
				TX_STOP: if (i_tx_run && !fatal_r) begin
					tx_st_r <= TX_DREAD;
					tx_cur_r <= tx_base;
					tx_ph_r <= 1'b0;
				end
				TX_DREAD: if (tx_ack) begin
					if (!tx_ph_r) begin
						tx_len_r <= i_dma_rdata[7:0];
						tx_eor_r <= i_dma_rdata[DESC_END_RING_BIT];
						tx_ph_r <= i_dma_rdata[DESC_OWN_BIT];
						if (!i_dma_rdata[DESC_OWN_BIT]) tx_st_r <= TX_SUSP;
					end else begin
						tx_buf_r <= i_dma_rdata;
						tx_cnt_r <= 8'h00;
						tx_ph_r <= 1'b0;
						tx_st_r <= (tx_len_r == 8'h00) ? TX_DWRITE : TX_FILL;
					end
				end
				TX_FILL: if (tx_ack) begin
					tx_data_r <= order_bytes(big, i_dma_rdata); // [RULE_01]
					tx_st_r <= TX_XMIT;
				end
				TX_XMIT: if (i_tx_ready) begin
					tx_cnt_r <= tx_cnt_r + 8'h01;
					tx_st_r <= (tx_cnt_r + 8'h01 == tx_len_r) ? TX_DWRITE : TX_FILL;
				end
				TX_DWRITE: if (tx_ack) begin
					tx_cur_r <= next_desc(tx_cur_r, tx_base, tx_eor_r, gap); // [RULE_02]
					tx_st_r <= TX_DREAD;
				end
				TX_SUSP: if (wr_txp) begin
					tx_st_r <= TX_DREAD; // [RULE_06]
				end else if (!i_tx_run) begin
					tx_st_r <= TX_STOP;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive path FIFO and walker
	rx_state_t rx_st_r;
	rx_word_t rx_head;
	logic rx_fvalid, rx_pop, rx_ph_r, rx_eor_r, rx_done_ev;
	logic [31:0] rx_cur_r, rx_buf_r;
	logic [7:0] rx_len_r, rx_cnt_r;

	stream_fifo #(.WIDTH($bits(rx_word_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rstn(rst_ok),
		.i_data(i_rx_word),
		.i_valid(i_rx_valid),
		.o_ready(o_rx_ready),
		.o_data(rx_head),
		.o_valid(rx_fvalid),
		.i_ready(rx_pop)
	);

	assign rx_pop = (rx_st_r == RX_DRAIN && rx_ack) || (rx_st_r == RX_FLUSH);
	assign rx_req = !fatal_r && (rx_st_r == RX_DREAD || rx_st_r == RX_DRAIN || rx_st_r == RX_DWRITE);
	assign rx_dma.write = rx_st_r != RX_DREAD;
	assign rx_dma.addr = (rx_st_r == RX_DRAIN) ? rx_buf_r + {22'h0, rx_cnt_r, 2'b00}
		: rx_cur_r + (rx_ph_r ? DESC_WORD1_OFFSET : 32'h0);
	assign rx_dma.wdata = (rx_st_r == RX_DRAIN) ? order_bytes(big, rx_head.data) // [RULE_01]
		: {1'b0, rx_eor_r, 22'h0, rx_cnt_r};
	assign rx_done_ev = rx_ack && rx_st_r == RX_DWRITE;

	always_ff @(posedge i_sys_clk) begin
		if (!rst_ok || i_dma_err) begin
			rx_st_r <= RX_STOP;
			rx_ph_r <= 1'b0;
		end else begin
			unique case (rx_st_r)
				RX_STOP: if (i_rx_run && !fatal_r) begin
					rx_st_r <= RX_DREAD;
					rx_cur_r <= rx_base;
					rx_ph_r <= 1'b0;
				end
				RX_DREAD: if (rx_ack) begin
					if (!rx_ph_r) begin
						rx_len_r <= i_dma_rdata[7:0];
						rx_eor_r <= i_dma_rdata[DESC_END_RING_BIT];
						rx_ph_r <= i_dma_rdata[DESC_OWN_BIT];
						if (!i_dma_rdata[DESC_OWN_BIT]) rx_st_r <= RX_SUSP;
					end else begin
						rx_buf_r <= i_dma_rdata;
						rx_cnt_r <= 8'h00;
						rx_ph_r <= 1'b0;
						rx_st_r <= RX_WAIT;
					end
				end
				RX_WAIT: if (rx_fvalid && rx_cnt_r == rx_len_r) begin
					rx_st_r <= RX_FLUSH;
				end else if (rx_fvalid) begin
					rx_st_r <= RX_DRAIN;
				end else if (!i_rx_run) begin
					rx_st_r <= RX_STOP;
				end
				RX_DRAIN: if (rx_ack) begin
					rx_cnt_r <= rx_cnt_r + 8'h01;
					rx_st_r <= rx_head.last ? RX_DWRITE : RX_WAIT;
				end
				RX_FLUSH: if (rx_fvalid && rx_head.last) begin
					rx_st_r <= RX_DWRITE;
				end
				RX_DWRITE: if (rx_ack) begin
					rx_st_r <= RX_CHECK;
				end
				RX_CHECK: begin
					rx_cur_r <= next_desc(rx_cur_r, rx_base, rx_eor_r, gap); // [RULE_02]
					rx_st_r <= RX_DREAD;
				end
				RX_SUSP: if (wr_rxp) begin
					rx_st_r <= RX_DREAD; // [RULE_07]
				end else if (!i_rx_run) begin
					rx_st_r <= RX_STOP;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags: hardware set wins over write-one clear
	logic txc_r, txm_r, rxc_r, sum_r;
	logic [2:0] kind_r;
	logic txc_nxt, txm_nxt, rxc_nxt;

	assign txc_nxt = tx_done_ev || (txc_r && !(wr_st && i_reg.wdata[ST_TX_COMPLETE_BIT]));
	assign txm_nxt = tx_miss_ev || (txm_r && !(wr_st && i_reg.wdata[ST_TX_DESC_MISSING_BIT]));
	assign rxc_nxt = rx_done_ev || (rxc_r && !(wr_st && i_reg.wdata[ST_RX_COMPLETE_BIT]));

	always_ff @(posedge i_sys_clk) begin
		if (!rst_ok) begin
			txc_r <= 1'b0;
			txm_r <= 1'b0;
			rxc_r <= 1'b0;
			sum_r <= 1'b0;
			fatal_r <= 1'b0;
			kind_r <= 3'h0;
		end else begin
			txc_r <= txc_nxt;
			txm_r <= txm_nxt;
			rxc_r <= rxc_nxt;
			sum_r <= txc_nxt || txm_nxt || rxc_nxt || (sum_r && !(wr_st && i_reg.wdata[ST_SUMMARY_BIT])); // [RULE_17]
			if (i_dma_err && grant_r != ARB_IDLE) begin
				fatal_r <= 1'b1; // [RULE_14]
				kind_r <= i_dma_err_kind;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read-back
	logic [31:0] cfg_rd, st_rd, rd_val;

	assign cfg_rd = {24'h0, cfg_r, soft_busy}; // [RULE_04] [RULE_18]
	assign st_rd = {6'h00, kind_r, tx_st_r, rx_st_r, sum_r, 2'b00, fatal_r, 6'h00, // [RULE_14] [RULE_15] [RULE_16]
		rxc_r, 3'b000, txm_r, 1'b0, txc_r}; // [RULE_18]
	assign rd_val = (i_reg.addr == OFF_BUS_ACCESS_CONFIG) ? cfg_rd
		: (i_reg.addr == OFF_TX_POLL_PORT || i_reg.addr == OFF_RX_POLL_PORT) ? POLL_PORT_READ
		: (i_reg.addr == OFF_RX_RING_BASE) ? rx_base
		: (i_reg.addr == OFF_TX_RING_BASE) ? tx_base
		: (i_reg.addr == OFF_MAIN_STATUS_WORD) ? st_rd : 32'h0;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) o_reg_rdata <= 32'h0;
		else if (i_reg.rd) o_reg_rdata <= rd_val;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_soft_start;
		wr_cfg && i_reg.wdata[CFG_SOFT_RESET_BIT] && !soft_busy;
	endsequence
	sequence s_soft_clear;
		soft_busy [*8] ##1 soft_busy [*8] ##1 !soft_busy;
	endsequence
	property p_soft_reset;
		s_soft_start |=> s_soft_clear;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not self clear"); // [RULE_04]

	property p_rx_base;
		disable iff (!rst_ok) wr_rxb |=> rx_base == {$past(i_reg.wdata[31:2]), 2'b00};
	endproperty
	a_rx_base: assert property (p_rx_base) else $error("rx ring base wrong"); // [RULE_10]

	property p_tx_base;
		disable iff (!rst_ok) wr_txb |=> tx_base[1:0] == 2'b00 && tx_base[31:2] == $past(i_reg.wdata[31:2]);
	endproperty
	a_tx_base: assert property (p_tx_base) else $error("tx ring base wrong"); // [RULE_11]

	property p_tx_poll;
		disable iff (!rst_ok) tx_st_r == TX_SUSP && wr_txp && !i_dma_err |=> tx_st_r == TX_DREAD ##0 tx_req;
	endproperty
	a_tx_poll: assert property (p_tx_poll) else $error("tx poll did not fetch"); // [RULE_06]

	property p_rx_poll;
		disable iff (!rst_ok) rx_st_r == RX_SUSP && wr_rxp && !i_dma_err |=> rx_st_r == RX_DREAD && !rx_dma.write;
	endproperty
	a_rx_poll: assert property (p_rx_poll) else $error("rx poll did not fetch"); // [RULE_07]

	property p_summary;
		disable iff (!rst_ok) (tx_done_ev || tx_miss_ev || rx_done_ev) |=> sum_r [*2];
	endproperty
	a_summary: assert property (p_summary) else $error("summary bit not latched"); // [RULE_17]

	property p_fault;
		disable iff (!rst_ok) i_dma_err && o_dma_req |=> fatal_r && kind_r == $past(i_dma_err_kind)
			&& tx_st_r == TX_STOP && rx_st_r == RX_STOP;
	endproperty
	a_fault: assert property (p_fault) else $error("bus fault not recorded"); // [RULE_14]

	property p_priority;
		disable iff (!rst_ok) grant_r == ARB_IDLE && tx_req && rx_req |=> grant_r == ($past(tx_first) ? ARB_TX : ARB_RX);
	endproperty
	a_priority: assert property (p_priority) else $error("bus priority wrong"); // [RULE_03]

	property p_tx_codes;
		tx_st_r != 3'b100 && tx_st_r != 3'b101;
	endproperty
	a_tx_codes: assert property (p_tx_codes) else $error("reserved tx state code"); // [RULE_15]

	property p_gap;
		disable iff (!rst_ok) tx_done_ev && !tx_eor_r |=> tx_cur_r == $past(tx_cur_r) + (($past(32'(gap)) + 32'd2) << 2);
	endproperty
	a_gap: assert property (p_gap) else $error("descriptor step wrong"); // [RULE_02]

	property p_reserved;
		i_reg.rd && i_reg.addr == OFF_MAIN_STATUS_WORD |=> o_reg_rdata[31:26] == 6'h00 && o_reg_rdata[15:14] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved status bits set"); // [RULE_18]
endmodule : dma_ring_csr

// *** core/ring_dma_pkg.sv ***
// Package: register map, field layout, states, carriers and helpers for the ring DMA control block
package ring_dma_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] OFF_BUS_ACCESS_CONFIG = 8'h00;
	localparam logic [7:0] OFF_TX_POLL_PORT = 8'h08;
	localparam logic [7:0] OFF_RX_POLL_PORT = 8'h10;
	localparam logic [7:0] OFF_RX_RING_BASE = 8'h18;
	localparam logic [7:0] OFF_TX_RING_BASE = 8'h20;
	localparam logic [7:0] OFF_MAIN_STATUS_WORD = 8'h28;

	// Reset and read-back values
	localparam logic [31:0] POLL_PORT_READ = 32'h0fffffff;
	localparam logic [31:0] RING_BASE_RESET = 32'h00000000;
	localparam logic [6:0] CFG_RESET = 7'h00;

	// Bus access config fields
	localparam int CFG_SOFT_RESET_BIT = 0;
	localparam int CFG_PRIORITY_BIT = 1;
	localparam int CFG_GAP_LSB = 2;
	localparam int CFG_GAP_MSB = 6;
	localparam int CFG_BYTE_ORDER_BIT = 7;

	// Status word fields
	localparam int ST_TX_COMPLETE_BIT = 0;
	localparam int ST_TX_DESC_MISSING_BIT = 2;
	localparam int ST_RX_COMPLETE_BIT = 6;
	localparam int ST_FATAL_BIT = 13;
	localparam int ST_SUMMARY_BIT = 16;
	localparam int ST_RX_STATE_LSB = 17;
	localparam int ST_TX_STATE_LSB = 20;
	localparam int ST_FAULT_KIND_LSB = 23;

	// Descriptor word 0 layout; word 1 holds the buffer address
	localparam int DESC_OWN_BIT = 31;
	localparam int DESC_END_RING_BIT = 30;
	localparam logic [31:0] DESC_WORDS = 32'h00000002;
	localparam logic [31:0] DESC_WORD1_OFFSET = 32'h00000004;

	// Soft reset sequence length in clock cycles
	localparam logic [4:0] SOFT_RESET_CYCLES = 5'h10;

	////////////////////////////////////////////////////////////////////////////
	// Process states
	typedef enum logic [2:0] {
		TX_STOP = 3'b000, TX_DREAD = 3'b001, TX_XMIT = 3'b010,
		TX_FILL = 3'b011, TX_SUSP = 3'b110, TX_DWRITE = 3'b111
	} tx_state_t;

	typedef enum logic [2:0] {
		RX_STOP = 3'b000, RX_DREAD = 3'b001, RX_CHECK = 3'b010, RX_WAIT = 3'b011,
		RX_SUSP = 3'b100, RX_DWRITE = 3'b101, RX_FLUSH = 3'b110, RX_DRAIN = 3'b111
	} rx_state_t;

	typedef enum logic [1:0] {
		ARB_IDLE = 2'b00, ARB_TX = 2'b01, ARB_RX = 2'b10
	} arb_t;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dma_req_t;

	typedef struct packed {
		logic last;
		logic [31:0] data;
	} rx_word_t;

	////////////////////////////////////////////////////////////////////////////
	// Byte lane swap for big-endian data buffers
	function automatic logic [31:0] order_bytes(input logic big, input logic [31:0] d);
		order_bytes = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
	endfunction : order_bytes

	// Next descriptor address: wrap to base or step over descriptor plus gap
	function automatic logic [31:0] next_desc(input logic [31:0] cur, input logic [31:0] base,
			input logic wrap, input logic [4:0] gap);
		next_desc = wrap ? base : cur + ((DESC_WORDS + {27'h0000000, gap}) << 2);
	endfunction : next_desc
endpackage : ring_dma_pkg

// *** core/soft_reset_seq.sv ***
// Self-clearing soft reset sequencer
module soft_reset_seq import ring_dma_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	output logic o_busy
);
	logic [4:0] cnt_r;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			cnt_r <= 5'h00;
		end else if (i_start && cnt_r == 5'h00) begin
			cnt_r <= SOFT_RESET_CYCLES;
		end else if (cnt_r != 5'h00) begin
			cnt_r <= cnt_r - 5'h01;
		end
	end

	assign o_busy = (cnt_r != 5'h00);
endmodule : soft_reset_seq

// *** core/stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
module stream_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [WIDTH-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign o_ready = (cnt_r != (AW+1)'(DEPTH));
	assign o_valid = (cnt_r != '0);
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem_r[rp_r];

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_r[wp_r] <= i_data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1)) : wp_r;
			rp_r <= pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1)) : rp_r;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : stream_fifo

// *** test/host_mem_model.sv ***
// Host memory model answering the ring DMA bus master
module host_mem_model import ring_dma_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire dma_req_t i_dma,
	input wire logic i_dma_req,
	input wire logic [1:0] i_delay,
	input wire logic i_fail,
	input wire logic [2:0] i_fail_kind,
	output logic o_ack,
	output logic o_err,
	output logic [2:0] o_err_kind,
	output logic [31:0] o_rdata,
	output logic [31:0] o_last_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [0:255];
	logic [31:0] rdata_r;
	logic [1:0] wait_r;
	logic done_r;
	////////////////////////////////////////////////////////////////////////////
	// Answer lines scrambled outside the answering cycle
	assign o_rdata = o_ack ? rdata_r : ~rdata_r;
	assign o_err_kind = o_err ? i_fail_kind : ~i_fail_kind;
	initial begin
		o_ack = 1'b0;
		o_err = 1'b0;
		rdata_r = 32'h5a5a5a5a;
		o_last_addr = 32'h0;
	end
	always @(posedge i_sys_clk) begin
		o_ack <= 1'b0;
		o_err <= 1'b0;
		if (!i_rstn || !i_dma_req) begin
			wait_r <= 2'h0;
			done_r <= 1'b0;
		end else if (!done_r && wait_r == i_delay) begin
			done_r <= 1'b1;
			o_last_addr <= i_dma.addr;
			if (i_fail) begin
				o_err <= 1'b1;
			end else begin
				o_ack <= 1'b1;
				rdata_r <= mem[i_dma.addr[9:2]];
				if (i_dma.write) begin
					mem[i_dma.addr[9:2]] <= i_dma.wdata;
				end
			end
		end else if (!done_r) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule : host_mem_model

// *** test/dma_ring_csr_tb.sv ***
// Self-checking bench for the ring DMA control and status block
module dma_ring_csr_tb import ring_dma_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	reg_req_t i_reg = '0;
	logic [31:0] o_reg_rdata, dma_rdata, o_tx_data, last_addr, rv;
	logic [31:0] tx_seen = 32'h0;
	logic i_tx_run = 1'b0;
	logic i_rx_run = 1'b0;
	dma_req_t o_dma;
	logic o_dma_req, dma_ack, dma_err, o_tx_valid, o_rx_ready;
	logic [2:0] err_kind;
	logic i_tx_ready = 1'b1;
	rx_word_t i_rx_word = '0;
	logic i_rx_valid = 1'b0;
	logic [1:0] delay = 2'h0;
	logic fail = 1'b0;
	logic [2:0] fail_kind = 3'h0;
	int n_mismatch = 0;
	int samples_checked = 0;
	always #10 i_sys_clk = ~i_sys_clk;
	dma_ring_csr dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
		.i_tx_run(i_tx_run), .i_rx_run(i_rx_run), .o_dma(o_dma), .o_dma_req(o_dma_req), .i_dma_ack(dma_ack),
		.i_dma_err(dma_err), .i_dma_err_kind(err_kind), .i_dma_rdata(dma_rdata), .o_tx_data(o_tx_data),
		.o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .i_rx_word(i_rx_word), .i_rx_valid(i_rx_valid),
		.o_rx_ready(o_rx_ready));
	host_mem_model host_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_dma(o_dma), .i_dma_req(o_dma_req),
		.i_delay(delay), .i_fail(fail), .i_fail_kind(fail_kind), .o_ack(dma_ack), .o_err(dma_err),
		.o_err_kind(err_kind), .o_rdata(dma_rdata), .o_last_addr(last_addr));
	always @(posedge i_sys_clk) begin
		if (o_tx_valid === 1'b1 && i_tx_ready) begin
			tx_seen <= o_tx_data;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task conclude;
		if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge i_sys_clk);
		i_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_sys_clk);
		i_reg = '0;
	endtask : wr
	task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(negedge i_sys_clk);
		i_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(negedge i_sys_clk);
		i_reg = '0;
		rv = o_reg_rdata;
		if (what != "") chk(rv, exp, what);
	endtask : rchk
	task wait_status(input logic [31:0] mask, input logic [31:0] val);
		int i;
		for (i = 0; i < 300; i++) begin
			rchk(OFF_MAIN_STATUS_WORD, 32'h0, "");
			if ((rv & mask) === val) return;
		end
		n_mismatch++;
		$display("Error at %0t: status wait timed out", $time);
		conclude();
	endtask : wait_status
	task soft_reset;
		i_tx_run = 1'b0;
		i_rx_run = 1'b0;
		wr(OFF_BUS_ACCESS_CONFIG, 32'h0000008f);
	endtask : soft_reset
	////////////////////////////////////////////////////////////////////////////
	task t_reset_values;
		rchk(OFF_BUS_ACCESS_CONFIG, 32'h0, "config reset");
		rchk(OFF_TX_POLL_PORT, POLL_PORT_READ, "tx poll read");
		rchk(OFF_RX_POLL_PORT, POLL_PORT_READ, "rx poll read");
		rchk(OFF_RX_RING_BASE, RING_BASE_RESET, "rx base reset");
		rchk(OFF_TX_RING_BASE, RING_BASE_RESET, "tx base reset");
		rchk(OFF_MAIN_STATUS_WORD, 32'h0, "status reset");
	endtask : t_reset_values
	task t_reg_access;
		wr(OFF_BUS_ACCESS_CONFIG, 32'hffffff8e);
		rchk(OFF_BUS_ACCESS_CONFIG, 32'h0000008e, "config fields");
		wr(OFF_RX_RING_BASE, 32'h00000203);
		rchk(OFF_RX_RING_BASE, 32'h00000200, "rx base align");
		wr(OFF_TX_RING_BASE, 32'h00000103);
		rchk(OFF_TX_RING_BASE, 32'h00000100, "tx base align");
		wr(OFF_TX_POLL_PORT, 32'h12345678);
		rchk(OFF_TX_POLL_PORT, POLL_PORT_READ, "poll stores nothing");
		rchk(8'h30, 32'h0, "unmapped read");
		wr(OFF_MAIN_STATUS_WORD, 32'hfc00affa);
		rchk(OFF_MAIN_STATUS_WORD, 32'h0, "status ignores writes");
	endtask : t_reg_access
	task t_tx;
		host_u.mem[64] = 32'h00000001;
		host_u.mem[65] = 32'h00000180;
		host_u.mem[96] = 32'h11223344;
		host_u.mem[69] = 32'h00000000;
		i_tx_run = 1'b1;
		wait_status(32'h00700000, 32'h00600000);
		chk(rv & 32'h00010005, 32'h00010004, "tx missing summary");
		host_u.mem[64] = 32'h80000001;
		wr(OFF_TX_POLL_PORT, 32'h0);
		wait_status(32'h00700001, 32'h00600001);
		chk(tx_seen, 32'h44332211, "tx big endian data");
		chk(host_u.mem[64], 32'h00000001, "tx descriptor written back");
		chk(last_addr, 32'h00000114, "tx next descriptor gap");
	endtask : t_tx
	task t_rx;
		host_u.mem[128] = 32'h00000000;
		host_u.mem[129] = 32'h00000280;
		host_u.mem[133] = 32'h00000000;
		delay = 2'h3;
		i_rx_run = 1'b1;
		wait_status(32'h000e0000, 32'h00080000);
		host_u.mem[128] = 32'h80000004;
		wr(OFF_RX_POLL_PORT, 32'h0);
		chk({31'h0, o_rx_ready}, 32'h1, "rx fifo ready");
		@(negedge i_sys_clk);
		i_rx_word = '{last: 1'b1, data: 32'ha1b2c3d4};
		i_rx_valid = 1'b1;
		@(negedge i_sys_clk);
		i_rx_valid = 1'b0;
		wait_status(32'h000e0040, 32'h00080040);
		chk(host_u.mem[160], 32'hd4c3b2a1, "rx big endian data");
		chk(host_u.mem[128], 32'h00000001, "rx descriptor written back");
		chk(last_addr, 32'h00000214, "rx next descriptor gap");
	endtask : t_rx
	task t_soft_reset;
		soft_reset();
		rchk(OFF_BUS_ACCESS_CONFIG, 32'h00000001, "soft reset busy");
		wr(OFF_TX_RING_BASE, 32'h00000040);
		repeat (20) @(negedge i_sys_clk);
		rchk(OFF_BUS_ACCESS_CONFIG, 32'h0, "soft reset self clear");
		rchk(OFF_TX_RING_BASE, 32'h0, "base cleared and write ignored");
		rchk(OFF_MAIN_STATUS_WORD, 32'h0, "status cleared");
	endtask : t_soft_reset
	task t_priority(input logic [31:0] cfg, input logic [31:0] exp);
		int i;
		soft_reset();
		repeat (20) @(negedge i_sys_clk);
		wr(OFF_BUS_ACCESS_CONFIG, cfg);
		wr(OFF_RX_RING_BASE, 32'h00000200);
		wr(OFF_TX_RING_BASE, 32'h00000100);
		@(negedge i_sys_clk);
		i_tx_run = 1'b1;
		i_rx_run = 1'b1;
		for (i = 0; i < 20 && o_dma_req !== 1'b1; i++) @(negedge i_sys_clk);
		chk({31'h0, o_dma_req}, 32'h1, "bus request raised");
		chk(o_dma.addr, exp, "bus priority");
		wait_status(32'h007e0000, 32'h00680000);
	endtask : t_priority
	task t_fatal;
		int k;
		int seen;
		fail = 1'b1;
		delay = 2'h1;
		host_u.mem[0] = 32'h80000001;
		for (k = 0; k < 3; k++) begin
			soft_reset();
			repeat (20) @(negedge i_sys_clk);
			fail_kind = k[2:0];
			i_tx_run = 1'b1;
			wait_status(32'h00002000, 32'h00002000);
			chk(rv & 32'h03800000, {6'h0, k[2:0], 23'h0}, "bus fault kind");
		end
		seen = 0;
		repeat (40) begin
			@(negedge i_sys_clk);
			if (o_dma_req !== 1'b0) seen++;
		end
		chk(seen, 32'h0, "no bus access after fault");
	endtask : t_fatal
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge i_sys_clk);
		i_rstn = 1'b1;
		t_reset_values();
		t_reg_access();
		t_tx();
		t_rx();
		t_soft_reset();
		t_priority(32'h00000000, 32'h00000200);
		t_priority(32'h00000002, 32'h00000100);
		t_fatal();
		conclude();
	end
endmodule : dma_ring_csr_tb
